// ==== logic/dlic_pkg.sv ====
// Constants, register map and carrier types of the dual-level interrupt controller
package dlic_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned STRB_W = DATA_W / 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_NORM_RAW   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_NORM_MASK  = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_NORM_CLR   = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_NORM_STAT  = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_FAST_RAW   = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_FAST_MASK  = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_FAST_CLR   = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_FAST_STAT  = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_SOFT_CFG   = 12'h020;

	// Source bit positions, shared by every status and mask register
	localparam int unsigned BIT_FAST_ALL = 0;
	localparam int unsigned BIT_PROG     = 1;
	localparam int unsigned SRC_LO       = 2;
	localparam int unsigned SRC_HI       = 24;
	localparam int unsigned SRC_N        = SRC_HI - SRC_LO + 1;
	localparam int unsigned EXT_N        = 4;

	// Soft interrupt configuration bits
	localparam int unsigned CFG_PROG_NORM = 1;
	localparam int unsigned CFG_PROG_FAST = 2;

	// Writable bits and reset values of the masks and of the soft configuration
	localparam logic [DATA_W-1:0] MASK_VALID = 32'h01fffffc;
	localparam logic [DATA_W-1:0] CFG_VALID  = 32'h00000006;
	localparam logic [DATA_W-1:0] MASK_RST   = 32'h00000000;
	localparam logic [DATA_W-1:0] CFG_RST    = 32'h00000000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// On-chip request lines, one field per source (external pins come separately)
	typedef struct packed {
		logic pwm_sync;
		logic pwm_trip;
		logic logic_array1;
		logic logic_array0;
		logic supply_monitor;
		logic comparator;
		logic uart;
		logic spi_master;
		logic spi_slave;
		logic i2c1_master;
		logic i2c0_master;
		logic i2c0_slave;
		logic pll_lock;
		logic adc;
		logic flash;
		logic watchdog;
		logic wakeup;
		logic timer1;
		logic timer0;
	} dlic_src_t;

	// Outputs to the processor core
	typedef struct packed {
		logic normal_request;
		logic fast_exception_request;
	} dlic_core_t;
endpackage

// ==== logic/dlic_top.sv ====
// Dual-level interrupt controller with an AXI4-Lite register slave
// Function
// RULE1: Accept 23 separately maskable interrupt sources.
// RULE2: Same bit index, same source, every register.
// RULE3: Bits 2-8: timers, flash, converter, lock.
// RULE4: Bits 9-24: serial, pins, monitors, array, pwm.
// RULE5: Raw status follows live request lines.
// RULE6: Mask bit one enables, zero blocks source.
// RULE7: Mask write sets ones, ignores zeros.
// RULE8: Clear register drops mask bits written one.
// RULE9: Enabled status is raw gated by mask.
// RULE10: Normal output ORs all normal status bits.
// RULE11: No priority encoding, no vector generated.
// RULE12: Fast level has identical four registers.
// RULE13: Fast output ORs bits 31-1; mirrored bit 0.
// RULE14: Fast mask write one clears normal bit.
// RULE15: Normal mask write one clears fast bit.
// RULE16: Bit 1 inert in masks and clears.
// RULE17: Programmed interrupts unmaskable, set by config.
// RULE18: Config bit 2 drives fast bit 1.
// RULE19: Config bit 1 drives normal bit 1.
// RULE20: Peripherals hold requests past interrupt latency.
`timescale 1ns/1ns
module dlic_top (
	input  wire logic                               clk_sys,
	input  wire logic                               rst_b,
	input  wire dlic_pkg::dlic_src_t                periph_req,
	input  wire logic [dlic_pkg::EXT_N-1:0]         ext_req_pin,
	output dlic_pkg::dlic_core_t                    core_req,
	input  wire logic [dlic_pkg::ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [dlic_pkg::DATA_W-1:0]        s_axi_wdata,
	input  wire logic [dlic_pkg::STRB_W-1:0]        s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [dlic_pkg::ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [dlic_pkg::DATA_W-1:0]             s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready
);
	logic [dlic_pkg::EXT_N-1:0]   ext_s1_r;
	logic [dlic_pkg::EXT_N-1:0]   ext_s2_r;
	logic [dlic_pkg::SRC_N-1:0]   src_q_r;
	logic [dlic_pkg::SRC_N-1:0]   src_nxt;
	logic [dlic_pkg::DATA_W-1:0]  norm_mask_r;
	logic [dlic_pkg::DATA_W-1:0]  fast_mask_r;
	logic [dlic_pkg::DATA_W-1:0]  soft_cfg_r;
	logic [dlic_pkg::DATA_W-1:0]  norm_raw;
	logic [dlic_pkg::DATA_W-1:0]  fast_raw;
	logic [dlic_pkg::DATA_W-1:0]  norm_stat;
	logic [dlic_pkg::DATA_W-1:0]  fast_stat;
	logic [dlic_pkg::DATA_W-1:0]  src_word;
	logic                         fast_any;
	logic                         norm_req_r;
	logic                         fast_req_r;
	logic [dlic_pkg::ADDR_W-1:0]  awaddr_r;
	logic                         aw_hold_r;
	logic [dlic_pkg::DATA_W-1:0]  wdata_r;
	logic [dlic_pkg::STRB_W-1:0]  wstrb_r;
	logic                         w_hold_r;
	logic                         bvalid_r;
	logic [1:0]                   bresp_r;
	logic                         rvalid_r;
	logic [1:0]                   rresp_r;
	logic [dlic_pkg::DATA_W-1:0]  rdata_r;
	logic                         wr_fire;
	logic [dlic_pkg::DATA_W-1:0]  lane_mask;
	logic [dlic_pkg::DATA_W-1:0]  wr_bits;
	logic [dlic_pkg::DATA_W-1:0]  wr_mask_bits;
	logic                         wr_mapped;
	logic [dlic_pkg::DATA_W-1:0]  rd_word;
	logic                         rd_mapped;

	// External pins are asynchronous: two stages before anything looks at them
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ext_s1_r <= '0;
			ext_s2_r <= '0;
		end else begin
			ext_s1_r <= ext_req_pin;
			ext_s2_r <= ext_s1_r;
		end
	end

	// Place each request at its fixed index, high index first
	always_comb begin
		src_nxt = {
			periph_req.pwm_sync,        // RULE4
			periph_req.pwm_trip,
			ext_s2_r[3],
			ext_s2_r[2],
			periph_req.logic_array1,
			periph_req.logic_array0,
			ext_s2_r[1],
			periph_req.supply_monitor,
			periph_req.comparator,
			ext_s2_r[0],
			periph_req.uart,
			periph_req.spi_master,
			periph_req.spi_slave,
			periph_req.i2c1_master,
			periph_req.i2c0_master,
			periph_req.i2c0_slave,
			periph_req.pll_lock,        // RULE3
			periph_req.adc,
			periph_req.flash,
			periph_req.watchdog,
			periph_req.wakeup,
			periph_req.timer1,
			periph_req.timer0
		};
	end

	// Sample the level-type requests; no latching, a dropped request clears at once
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			src_q_r <= '0;
		end else begin
			src_q_r <= src_nxt; // RULE5 RULE20
		end
	end

	// Sources widened to a register word; the same word feeds both levels
	always_comb begin
		src_word = '0;
		src_word[dlic_pkg::SRC_HI:dlic_pkg::SRC_LO] = src_q_r; // RULE1 RULE2
	end

	// Fast level first, since its combined request lands in bit 0 of both levels
	always_comb begin
		fast_raw = src_word; // RULE12
		fast_raw[dlic_pkg::BIT_PROG] = soft_cfg_r[dlic_pkg::CFG_PROG_FAST]; // RULE17 RULE18
		fast_stat = fast_raw & fast_mask_r; // RULE9 RULE6
		fast_stat[dlic_pkg::BIT_PROG] = soft_cfg_r[dlic_pkg::CFG_PROG_FAST]; // RULE17
		fast_any = |fast_stat[dlic_pkg::DATA_W-1:1]; // RULE13
		fast_raw[dlic_pkg::BIT_FAST_ALL] = fast_any; // RULE13
		fast_stat[dlic_pkg::BIT_FAST_ALL] = fast_any;
	end

	// Normal level; bit 0 shows the fast request, so a fast event also wakes it
	always_comb begin
		norm_raw = src_word;
		norm_raw[dlic_pkg::BIT_PROG] = soft_cfg_r[dlic_pkg::CFG_PROG_NORM]; // RULE19
		norm_raw[dlic_pkg::BIT_FAST_ALL] = fast_any; // RULE13
		norm_stat = norm_raw & norm_mask_r; // RULE9 RULE6
		norm_stat[dlic_pkg::BIT_PROG] = soft_cfg_r[dlic_pkg::CFG_PROG_NORM]; // RULE17 RULE19
		norm_stat[dlic_pkg::BIT_FAST_ALL] = fast_any;
	end

	// Plain OR of status words; the handler finds the source itself
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			norm_req_r <= 1'b0;
			fast_req_r <= 1'b0;
		end else begin
			norm_req_r <= |norm_stat; // RULE10 RULE11
			fast_req_r <= fast_any; // RULE13
		end
	end

	// One driver for the whole carrier; normal request is the upper field
	assign core_req = {norm_req_r, fast_req_r};

	// Write address and data are held independently; either may come first
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			w_hold_r <= 1'b0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_hold_r <= 1'b0;
		end
	end

	// Byte strobes gate which data bits count as written ones
	genvar gi;
	generate
		for (gi = 0; gi < dlic_pkg::STRB_W; gi++) begin : g_lane
			assign lane_mask[gi*8 +: 8] = {8{wstrb_r[gi]}};
		end
	endgenerate

	assign wr_bits      = wdata_r & lane_mask;
	assign wr_mask_bits = wr_bits & dlic_pkg::MASK_VALID; // RULE16

	// Status registers are read-only: writes to them are accepted and dropped
	always_comb begin
		case (awaddr_r)
			dlic_pkg::OFS_NORM_RAW,
			dlic_pkg::OFS_NORM_MASK,
			dlic_pkg::OFS_NORM_CLR,
			dlic_pkg::OFS_NORM_STAT,
			dlic_pkg::OFS_FAST_RAW,
			dlic_pkg::OFS_FAST_MASK,
			dlic_pkg::OFS_FAST_CLR,
			dlic_pkg::OFS_FAST_STAT,
			dlic_pkg::OFS_SOFT_CFG: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// Normal mask: set-only writes, separate clear, and eviction by fast enables
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			norm_mask_r <= dlic_pkg::MASK_RST;
		end else if (wr_fire) begin
			case (awaddr_r)
				dlic_pkg::OFS_NORM_MASK: norm_mask_r <= norm_mask_r | wr_mask_bits; // RULE7
				dlic_pkg::OFS_NORM_CLR:  norm_mask_r <= norm_mask_r & ~wr_mask_bits; // RULE8
				dlic_pkg::OFS_FAST_MASK: norm_mask_r <= norm_mask_r & ~wr_mask_bits; // RULE14
				default:                 norm_mask_r <= norm_mask_r;
			endcase
		end
	end

	// Fast mask mirrors the normal one; a source can never be on both levels
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fast_mask_r <= dlic_pkg::MASK_RST;
		end else if (wr_fire) begin
			case (awaddr_r)
				dlic_pkg::OFS_FAST_MASK: fast_mask_r <= fast_mask_r | wr_mask_bits; // RULE12 RULE7
				dlic_pkg::OFS_FAST_CLR:  fast_mask_r <= fast_mask_r & ~wr_mask_bits; // RULE8
				dlic_pkg::OFS_NORM_MASK: fast_mask_r <= fast_mask_r & ~wr_mask_bits; // RULE15
				default:                 fast_mask_r <= fast_mask_r;
			endcase
		end
	end

	// Soft configuration is a plain register; only bits 2 and 1 exist
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			soft_cfg_r <= dlic_pkg::CFG_RST;
		end else if (wr_fire && awaddr_r == dlic_pkg::OFS_SOFT_CFG) begin
			soft_cfg_r <= ((soft_cfg_r & ~lane_mask) | wr_bits) & dlic_pkg::CFG_VALID;
		end
	end

	// Write response one cycle after both halves are held
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_r <= 1'b0;
			bresp_r  <= dlic_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_mapped ? dlic_pkg::RESP_OKAY : dlic_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// Read decode; clear registers are write-only and read as zero
	always_comb begin
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			dlic_pkg::OFS_NORM_RAW:  rd_word = norm_raw;
			dlic_pkg::OFS_NORM_MASK: rd_word = norm_mask_r;
			dlic_pkg::OFS_NORM_CLR:  rd_word = '0;
			dlic_pkg::OFS_NORM_STAT: rd_word = norm_stat;
			dlic_pkg::OFS_FAST_RAW:  rd_word = fast_raw;
			dlic_pkg::OFS_FAST_MASK: rd_word = fast_mask_r;
			dlic_pkg::OFS_FAST_CLR:  rd_word = '0;
			dlic_pkg::OFS_FAST_STAT: rd_word = fast_stat;
			dlic_pkg::OFS_SOFT_CFG:  rd_word = soft_cfg_r;
			default: begin
				rd_word   = '0;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// One read at a time; a new address is refused while data is waiting
	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= dlic_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_mapped ? dlic_pkg::RESP_OKAY : dlic_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;
endmodule // dlic_top

// ==== tb/dlic_periph_model.sv ====
// Request sources: peripherals and pins driven from a register-bit view
`timescale 1ns/1ns
module dlic_periph_model (
	input  wire logic [31:0]             src_cmd,
	output dlic_pkg::dlic_src_t          periph_req,
	output logic [dlic_pkg::EXT_N-1:0]   ext_req_pin
);
	// Levels stay up as long as commanded, well past the latency
	assign periph_req = dlic_pkg::dlic_src_t'({src_cmd[24:23], src_cmd[20:19],
		src_cmd[17:16], src_cmd[14:2]});
	assign ext_req_pin = {src_cmd[22:21], src_cmd[18], src_cmd[15]};
endmodule // dlic_periph_model

// ==== tb/dlic_props.sv ====
// Port-level assertions for the dual-level interrupt controller
`timescale 1ns/1ns
module dlic_props (
	input wire logic                       clk_sys,
	input wire logic                       rst_b,
	input wire dlic_pkg::dlic_core_t       core_req,
	input wire logic [dlic_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [dlic_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [dlic_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Both halves of a write taken at one edge
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answered: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_bad_write_err: assert property (wr_both and s_axi_awaddr >= 12'h024
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == dlic_pkg::RESP_SLVERR))
		else $error("unmapped write not refused");
	a_bad_read_err: assert property (rd_take and s_axi_araddr >= 12'h024 |=>
		s_axi_rvalid && s_axi_rresp == dlic_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_clear_reads_zero: assert property (rd_take and (s_axi_araddr == dlic_pkg::OFS_NORM_CLR
		|| s_axi_araddr == dlic_pkg::OFS_FAST_CLR) |=> s_axi_rdata == 32'h0)
		else $error("clear register read not zero");
	a_mask_bits_inert: assert property (rd_take and s_axi_araddr == dlic_pkg::OFS_NORM_MASK
		|=> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:25] == 7'h00)
		else $error("mask holds a reserved bit");
	a_cfg_reserved: assert property (rd_take and s_axi_araddr == dlic_pkg::OFS_SOFT_CFG
		|=> (s_axi_rdata & ~dlic_pkg::CFG_VALID) == 32'h0)
		else $error("config holds a reserved bit");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_fast_in_normal: assert property (core_req.fast_exception_request |->
		core_req.normal_request)
		else $error("fast request missing from normal");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
endmodule // dlic_props

bind dlic_top dlic_props u_dlic_props (.*);

// ==== tb/test_dlic_top.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module test_dlic_top;
	logic                 clk_sys = 1'b0;
	logic                 rst_b = 1'b0;
	logic [31:0]          src_cmd = 32'h0;
	dlic_pkg::dlic_src_t  periph_req;
	logic [3:0]           ext_req_pin;
	dlic_pkg::dlic_core_t core_req;
	logic [11:0]          s_axi_awaddr = 12'h000;
	logic                 s_axi_awvalid = 1'b0;
	logic                 s_axi_awready;
	logic [31:0]          s_axi_wdata = 32'h0;
	logic [3:0]           s_axi_wstrb = 4'h0;
	logic                 s_axi_wvalid = 1'b0;
	logic                 s_axi_wready;
	logic [1:0]           s_axi_bresp;
	logic                 s_axi_bvalid;
	logic                 s_axi_bready = 1'b0;
	logic [11:0]          s_axi_araddr = 12'h000;
	logic                 s_axi_arvalid = 1'b0;
	logic                 s_axi_arready;
	logic [31:0]          s_axi_rdata;
	logic [1:0]           s_axi_rresp;
	logic                 s_axi_rvalid;
	logic                 s_axi_rready = 1'b0;
	int                   num_checks = 0;
	int                   n_mismatch = 0;
	int                   lag = 0;
	logic [31:0]          b;

	// 125 MHz
	always #4 clk_sys = ~clk_sys;

	dlic_top u_dlic_top (.*);
	dlic_periph_model u_dlic_periph_model (.*);

	// Verdict in one place
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n = 0;
		logic ad = 1'b0;
		logic wd = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(ad && wd) && n < 50);
		// A lagging master lets the response wait, so the slave must hold it
		repeat (lag) @(posedge clk_sys);
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		`CHK("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp})
	endtask

	// Bus read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge clk_sys);
			n++;
		end while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 1'b0;
		repeat (lag) @(posedge clk_sys);
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		`CHK("rdata", {1'b1, er, e}, {s_axi_rvalid, s_axi_rresp, s_axi_rdata})
	endtask

	// Hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		results();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(dlic_pkg::OFS_NORM_MASK, 32'h0, 2'h0);
		rd(dlic_pkg::OFS_FAST_MASK, 32'h0, 2'h0);
		rd(dlic_pkg::OFS_SOFT_CFG, 32'h0, 2'h0);
		// Each source through both levels; the ext pins need the longer settle
		for (int i = 2; i <= 24; i++) begin
			b = 32'h1 << i;
			src_cmd <= b;
			repeat (6) @(posedge clk_sys);
			wr(dlic_pkg::OFS_NORM_MASK, b, 4'hf, 2'h0);
			rd(dlic_pkg::OFS_NORM_RAW, b, 2'h0);
			rd(dlic_pkg::OFS_NORM_STAT, b, 2'h0);
			`CHK("core", 2'b10, core_req)
			wr(dlic_pkg::OFS_FAST_MASK, b, 4'hf, 2'h0);
			rd(dlic_pkg::OFS_NORM_MASK, 32'h0, 2'h0);
			rd(dlic_pkg::OFS_FAST_STAT, b | 32'h1, 2'h0);
			rd(dlic_pkg::OFS_NORM_STAT, 32'h1, 2'h0);
			`CHK("core", 2'b11, core_req)
			wr(dlic_pkg::OFS_FAST_CLR, b, 4'hf, 2'h0);
			rd(dlic_pkg::OFS_FAST_MASK, 32'h0, 2'h0);
		end
		// Dropped requests leave raw status, pins once their sync has passed
		src_cmd <= 32'h0;
		repeat (6) @(posedge clk_sys);
		rd(dlic_pkg::OFS_NORM_RAW, 32'h0, 2'h0);
		rd(dlic_pkg::OFS_FAST_RAW, 32'h0, 2'h0);
		// Set-only masks, cross-clearing, selective clear, inert bits, strobes
		wr(dlic_pkg::OFS_FAST_MASK, 32'h30, 4'hf, 2'h0);
		wr(dlic_pkg::OFS_NORM_MASK, 32'h10, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_FAST_MASK, 32'h20, 2'h0);
		wr(dlic_pkg::OFS_NORM_MASK, 32'h0, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_NORM_MASK, 32'h10, 2'h0);
		wr(dlic_pkg::OFS_NORM_MASK, 32'hffffffff, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_NORM_MASK, 32'h01fffffc, 2'h0);
		rd(dlic_pkg::OFS_FAST_MASK, 32'h0, 2'h0);
		wr(dlic_pkg::OFS_NORM_CLR, 32'h00000f02, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_NORM_MASK, 32'h01fff0fc, 2'h0);
		wr(dlic_pkg::OFS_NORM_CLR, 32'hffffffff, 4'hf, 2'h0);
		wr(dlic_pkg::OFS_NORM_MASK, 32'h0001fffc, 4'h1, 2'h0);
		rd(dlic_pkg::OFS_NORM_MASK, 32'h000000fc, 2'h0);
		wr(dlic_pkg::OFS_NORM_CLR, 32'hffffffff, 4'hf, 2'h0);
		// Programmed interrupts bypass the empty masks
		wr(dlic_pkg::OFS_SOFT_CFG, 32'hffffffff, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_SOFT_CFG, 32'h6, 2'h0);
		rd(dlic_pkg::OFS_NORM_RAW, 32'h3, 2'h0);
		rd(dlic_pkg::OFS_FAST_RAW, 32'h3, 2'h0);
		rd(dlic_pkg::OFS_FAST_STAT, 32'h3, 2'h0);
		`CHK("core", 2'b11, core_req)
		wr(dlic_pkg::OFS_SOFT_CFG, 32'h2, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_FAST_STAT, 32'h0, 2'h0);
		rd(dlic_pkg::OFS_NORM_STAT, 32'h2, 2'h0);
		`CHK("core", 2'b10, core_req)
		wr(dlic_pkg::OFS_SOFT_CFG, 32'h0, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_NORM_STAT, 32'h0, 2'h0);
		`CHK("core", 2'b00, core_req)
		// Read-only, write-only and unmapped places, with a slow master
		lag = 2;
		wr(dlic_pkg::OFS_NORM_RAW, 32'hffffffff, 4'hf, 2'h0);
		rd(dlic_pkg::OFS_NORM_RAW, 32'h0, 2'h0);
		rd(dlic_pkg::OFS_NORM_CLR, 32'h0, 2'h0);
		wr(12'h024, 32'hffffffff, 4'hf, dlic_pkg::RESP_SLVERR);
		rd(12'h100, 32'h0, dlic_pkg::RESP_SLVERR);
		results();
	end
endmodule // test_dlic_top
